/* File: rtl/cpu_agen_defines.svh */
// Offsets, field positions, reset values and fixed addresses of the core
`ifndef CPU_AGEN_DEFINES_SVH
`define CPU_AGEN_DEFINES_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CMD 8'h00
`define OFS_INSN 8'h04
`define OFS_ACC 8'h08
`define OFS_TEMP 8'h0c
`define OFS_PC 8'h10
`define OFS_BASE 8'h14
`define OFS_MPTR 8'h18
`define OFS_BANK 8'h1c
`define OFS_CCR 8'h20
`define OFS_EA 8'h24
`define OFS_DATA 8'h28
`define OFS_STAT 8'h2c
// ----------------------------------------
// Fields and values
// ----------------------------------------
`define CCR_Z 2
`define STAT_BUSY 0
`define STAT_DONE 1
`define IMM_WORD_BIT 7
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define RST_WORD 16'h0000
// ----------------------------------------
// Address map constants
// ----------------------------------------
`define SHORT_LIMIT 8'h80
`define SHORT_BASE 16'h0080
`define LOW_PAGE 8'h00
`define GENREG_HI 8'h01
`define VEC_BASE 16'hffc0
`define PC_STEP1 16'h0001
`define PC_STEP2 16'h0002
`define DIV_STEPS 5'd16
`define DIV_LAST 5'd1
`endif

/* File: rtl/cpu_agen_pkg.sv */
// Types shared by the address generation and special operation core
package cpu_agen_pkg;
   // Commands written to the command register
   typedef enum logic [3:0] {
      OP_DIRECT = 4'h0, OP_BIT = 4'h1, OP_EXT = 4'h2, OP_INDEX = 4'h3,
      OP_POINTER = 4'h4, OP_GENREG = 4'h5, OP_IMM = 4'h6,
      OP_VECTOR = 4'h7, OP_REL = 4'h8, OP_INHERENT = 4'h9,
      OP_JUMP_ACC = 4'ha, OP_COPY_PC = 4'hb, OP_MULT = 4'hc,
      OP_DIV = 4'hd, OP_SWAP = 4'he
   } op_e;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_DIVIDE = 3'b001, ST_VEC_HI = 3'b010,
      ST_VEC_LO = 3'b011, ST_VEC_LOAD = 3'b100
   } state_e;
   // AXI4-Lite master to slave
   typedef struct packed {
      logic awvalid; logic [7:0] awaddr; logic wvalid;
      logic [31:0] wdata; logic [3:0] wstrb; logic bready;
      logic arvalid; logic [7:0] araddr; logic rready;
   } axi_req_s;
   // AXI4-Lite slave to master
   typedef struct packed {
      logic awready; logic wready; logic bvalid; logic [1:0] bresp;
      logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
   } axi_rsp_s;
   // Memory read request
   typedef struct packed {
      logic rd; logic [15:0] addr;
   } mem_req_s;
   // Whole state of the core
   typedef struct packed {
      state_e fsm; axi_rsp_s rsp; mem_req_s mem;
      logic aw_held; logic [7:0] aw_addr; logic w_held;
      logic [31:0] w_data; logic [3:0] w_strb;
      logic [15:0] acc; logic [15:0] temp; logic [15:0] pc;
      logic [15:0] offset_base_register; logic [15:0] memory_pointer;
      logic [2:0] bank_select_pointer; logic [4:0] register_window_select;
      logic [3:0] ccr; logic [7:0] opcode; logic [7:0] operand1;
      logic [7:0] operand2; logic [15:0] ea; logic [2:0] bit_pos;
      logic [15:0] data_word; logic busy; logic done;
      logic [4:0] div_cnt; logic [15:0] div_rem; logic [15:0] div_quo;
      logic [7:0] vec_hi;
   } core_state_s;
endpackage

/* File: rtl/cpu_agen_core.sv */
// Operand address generation and special operations, AXI4-Lite control
`timescale 1ns/1ns
`include "cpu_agen_defines.svh"

// Contract
// - Short-page operands below 0x80 map low, else banked
// - Bit operands use the same short-page byte map
// - Bit position comes from opcode low three bits
// - Full address: first byte high, second low
// - Indexed: sign-extended offset plus base register
// - Pointer register used directly as address
// - Banked register address high byte fixed 01
// - Immediate bytes are data; opcode picks width
// - Vector entry at 0xFFC0 plus twice index
// - Relative branch adds signed offset to PC
// - Jump via accumulator loads PC from accumulator
// - PC copy gives address of next instruction
// - Multiply low bytes, product into accumulator
// - Multiply leaves condition flags unchanged
// - Divide temp by acc, quotient and remainder
// - Zero divisor sets the zero flag
// - Divide leaves other flags unchanged
// - Swap branches to acc, acc gets next address
// - Bank select pointer is three bits wide
// - Register window select is five bits wide
module cpu_agen_core (
   input wire logic clk_sys, // System clock, 50 MHz
   input wire logic srst, // Synchronous reset, active high
   input wire cpu_agen_pkg::axi_req_s axi_req, // AXI4-Lite requests
   output cpu_agen_pkg::axi_rsp_s axi_rsp, // AXI4-Lite answers
   output cpu_agen_pkg::mem_req_s mem_req, // Vector table read request
   input wire logic [7:0] mem_rdata // Read byte, cycle after request
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   cpu_agen_pkg::core_state_s s; // Registered state
   cpu_agen_pkg::core_state_s next_s; // Next state

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   // Apply write strobes to a register image
   function automatic logic [31:0] merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] strb
   );
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Short-page byte to full address
   function automatic logic [15:0] short_map(
      input logic [7:0] o,
      input logic [2:0] bank
   );
      logic [15:0] r;
      r = {`LOW_PAGE, o};
      if (o >= `SHORT_LIMIT) begin
         // Upper half relocated into one of eight 128-byte banks
         r = `SHORT_BASE + {6'h00, bank, o[6:0]};
      end
      return r;
   endfunction

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   // Bus slave, command start and sequencer in one process
   always_comb begin
      logic [31:0] m;
      logic [31:0] rd;
      logic [16:0] trial;
      logic [16:0] diff;
      logic start;
      cpu_agen_pkg::op_e cmd;
      m = 32'h0000_0000;
      rd = 32'h0000_0000;
      trial = 17'h0_0000;
      diff = 17'h0_0000;
      start = 1'b0;
      cmd = cpu_agen_pkg::OP_DIRECT;
      next_s = s;

      // Write address capture
      if (s.rsp.awready && axi_req.awvalid) begin
         next_s.aw_held = 1'b1;
         next_s.aw_addr = axi_req.awaddr;
         next_s.rsp.awready = 1'b0;
      end
      // Write data capture
      if (s.rsp.wready && axi_req.wvalid) begin
         next_s.w_held = 1'b1;
         next_s.w_data = axi_req.wdata;
         next_s.w_strb = axi_req.wstrb;
         next_s.rsp.wready = 1'b0;
      end

      // Perform the write once address and data are both held
      if (s.aw_held && s.w_held && !s.rsp.bvalid) begin
         next_s.aw_held = 1'b0;
         next_s.w_held = 1'b0;
         next_s.rsp.bvalid = 1'b1;
         next_s.rsp.bresp = `RESP_OKAY;
         unique case (s.aw_addr)
            `OFS_CMD: begin
               // Commands while busy are dropped
               m = merge(32'h0000_0000, s.w_data, s.w_strb);
               start = !s.busy;
               cmd = cpu_agen_pkg::op_e'(m[3:0]);
            end
            `OFS_INSN: begin
               m = merge({8'h00, s.operand2, s.operand1, s.opcode},
                         s.w_data, s.w_strb);
               if (!s.busy) begin
                  next_s.opcode = m[7:0];
                  next_s.operand1 = m[15:8];
                  next_s.operand2 = m[23:16];
               end
            end
            `OFS_ACC: begin
               m = merge({16'h0000, s.acc}, s.w_data, s.w_strb);
               if (!s.busy) begin
                  next_s.acc = m[15:0];
               end
            end
            `OFS_TEMP: begin
               m = merge({16'h0000, s.temp}, s.w_data, s.w_strb);
               if (!s.busy) begin
                  next_s.temp = m[15:0];
               end
            end
            `OFS_PC: begin
               m = merge({16'h0000, s.pc}, s.w_data, s.w_strb);
               if (!s.busy) begin
                  next_s.pc = m[15:0];
               end
            end
            `OFS_BASE: begin
               m = merge({16'h0000, s.offset_base_register},
                         s.w_data, s.w_strb);
               if (!s.busy) begin
                  next_s.offset_base_register = m[15:0];
               end
            end
            `OFS_MPTR: begin
               m = merge({16'h0000, s.memory_pointer}, s.w_data, s.w_strb);
               if (!s.busy) begin
                  next_s.memory_pointer = m[15:0];
               end
            end
            `OFS_BANK: begin
               m = merge({19'h0_0000, s.register_window_select,
                          5'h00, s.bank_select_pointer},
                         s.w_data, s.w_strb);
               if (!s.busy) begin
                  next_s.bank_select_pointer = m[2:0];
                  next_s.register_window_select = m[12:8];
               end
            end
            `OFS_CCR: begin
               m = merge({28'h000_0000, s.ccr}, s.w_data, s.w_strb);
               if (!s.busy) begin
                  next_s.ccr = m[3:0];
               end
            end
            `OFS_STAT: begin
               // Write one to clear the done flag
               m = merge(32'h0000_0000, s.w_data, s.w_strb);
               if (m[`STAT_DONE]) begin
                  next_s.done = 1'b0;
               end
            end
            `OFS_EA, `OFS_DATA: begin
               // Read-only results, writes ignored
            end
            default: begin
               next_s.rsp.bresp = `RESP_SLVERR;
            end
         endcase
      end
      // Write response accepted, reopen both write channels
      if (s.rsp.bvalid && axi_req.bready) begin
         next_s.rsp.bvalid = 1'b0;
         next_s.rsp.awready = 1'b1;
         next_s.rsp.wready = 1'b1;
      end

      // Read address taken, data answered next cycle
      if (s.rsp.arready && axi_req.arvalid) begin
         next_s.rsp.arready = 1'b0;
         next_s.rsp.rvalid = 1'b1;
         next_s.rsp.rresp = `RESP_OKAY;
         unique case (axi_req.araddr)
            `OFS_CMD: rd = 32'h0000_0000;
            `OFS_INSN: rd = {8'h00, s.operand2, s.operand1, s.opcode};
            `OFS_ACC: rd = {16'h0000, s.acc};
            `OFS_TEMP: rd = {16'h0000, s.temp};
            `OFS_PC: rd = {16'h0000, s.pc};
            `OFS_BASE: rd = {16'h0000, s.offset_base_register};
            `OFS_MPTR: rd = {16'h0000, s.memory_pointer};
            `OFS_BANK: rd = {19'h0_0000, s.register_window_select,
                             5'h00, s.bank_select_pointer};
            `OFS_CCR: rd = {28'h000_0000, s.ccr};
            `OFS_EA: rd = {13'h0000, s.bit_pos, s.ea};
            `OFS_DATA: rd = {16'h0000, s.data_word};
            `OFS_STAT: rd = {30'h0000_0000, s.done, s.busy};
            default: begin
               rd = 32'h0000_0000;
               next_s.rsp.rresp = `RESP_SLVERR;
            end
         endcase
         next_s.rsp.rdata = rd;
      end
      // Read data accepted
      if (s.rsp.rvalid && axi_req.rready) begin
         next_s.rsp.rvalid = 1'b0;
         next_s.rsp.arready = 1'b1;
      end

      // Multi-cycle sequencer
      unique case (s.fsm)
         cpu_agen_pkg::ST_IDLE: begin
         end
         cpu_agen_pkg::ST_DIVIDE: begin
            // One restoring step per clock, divisor stays in acc
            trial = {s.div_rem, s.div_quo[15]};
            diff = trial - {1'b0, s.acc};
            next_s.div_quo = {s.div_quo[14:0], 1'b0};
            next_s.div_rem = trial[15:0];
            if (trial >= {1'b0, s.acc}) begin
               next_s.div_rem = diff[15:0];
               next_s.div_quo = {s.div_quo[14:0], 1'b1};
            end
            next_s.div_cnt = s.div_cnt - `DIV_LAST;
            if (s.div_cnt == `DIV_LAST) begin
               next_s.acc = next_s.div_quo;
               next_s.temp = next_s.div_rem;
               next_s.busy = 1'b0;
               next_s.done = 1'b1;
               next_s.fsm = cpu_agen_pkg::ST_IDLE;
            end
         end
         cpu_agen_pkg::ST_VEC_HI: begin
            // High byte requested, now ask for the low byte
            next_s.mem.addr = s.ea + `PC_STEP1;
            next_s.fsm = cpu_agen_pkg::ST_VEC_LO;
         end
         cpu_agen_pkg::ST_VEC_LO: begin
            // High byte arrives from the even address
            next_s.vec_hi = mem_rdata;
            next_s.mem.rd = 1'b0;
            next_s.fsm = cpu_agen_pkg::ST_VEC_LOAD;
         end
         cpu_agen_pkg::ST_VEC_LOAD: begin
            next_s.pc = {s.vec_hi, mem_rdata};
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
            next_s.fsm = cpu_agen_pkg::ST_IDLE;
         end
         default: begin
            next_s.busy = 1'b0;
            next_s.fsm = cpu_agen_pkg::ST_IDLE;
         end
      endcase

      // Command execution, single-cycle unless noted
      if (start) begin
         next_s.done = 1'b1;
         unique case (cmd)
            cpu_agen_pkg::OP_DIRECT: begin
               next_s.ea = short_map(s.operand1, s.bank_select_pointer);
            end
            cpu_agen_pkg::OP_BIT: begin
               next_s.ea = short_map(s.operand1,
                                     s.bank_select_pointer);
               next_s.bit_pos = s.opcode[2:0];
            end
            cpu_agen_pkg::OP_EXT: begin
               next_s.ea = {s.operand1, s.operand2};
            end
            cpu_agen_pkg::OP_INDEX: begin
               next_s.ea = s.offset_base_register +
                           {{8{s.operand1[7]}}, s.operand1};
            end
            cpu_agen_pkg::OP_POINTER: begin
               next_s.ea = s.memory_pointer;
            end
            cpu_agen_pkg::OP_GENREG: begin
               next_s.ea = {`GENREG_HI, s.register_window_select,
                            s.opcode[2:0]};
            end
            cpu_agen_pkg::OP_IMM: begin
               // Byte form zero-extends, word form is high then low
               next_s.data_word = {`LOW_PAGE, s.operand1};
               if (s.opcode[`IMM_WORD_BIT]) begin
                  next_s.data_word = {s.operand1, s.operand2};
               end
            end
            cpu_agen_pkg::OP_VECTOR: begin
               // Table read takes three more cycles
               next_s.ea = `VEC_BASE +
                           {12'h000, s.opcode[2:0], 1'b0};
               next_s.mem.addr = next_s.ea;
               next_s.mem.rd = 1'b1;
               next_s.busy = 1'b1;
               next_s.done = 1'b0;
               next_s.fsm = cpu_agen_pkg::ST_VEC_HI;
            end
            cpu_agen_pkg::OP_REL: begin
               // Base is the address after the two-byte branch
               next_s.pc = s.pc + `PC_STEP2 +
                           {{8{s.operand1[7]}}, s.operand1};
            end
            cpu_agen_pkg::OP_INHERENT: begin
               next_s.pc = s.pc + `PC_STEP1;
            end
            cpu_agen_pkg::OP_JUMP_ACC: begin
               next_s.pc = s.acc;
            end
            cpu_agen_pkg::OP_COPY_PC: begin
               next_s.acc = s.pc + `PC_STEP1;
               next_s.pc = s.pc + `PC_STEP1;
            end
            cpu_agen_pkg::OP_MULT: begin
               // Flags untouched, temp untouched
               next_s.acc = {8'h00, s.acc[7:0]} *
                            {8'h00, s.temp[7:0]};
            end
            cpu_agen_pkg::OP_DIV: begin
               // Only the zero flag may change
               if (s.acc == `RST_WORD) begin
                  next_s.ccr[`CCR_Z] = 1'b1;
               end
               next_s.div_rem = `RST_WORD;
               next_s.div_quo = s.temp;
               next_s.div_cnt = `DIV_STEPS;
               next_s.busy = 1'b1;
               next_s.done = 1'b0;
               next_s.fsm = cpu_agen_pkg::ST_DIVIDE;
            end
            cpu_agen_pkg::OP_SWAP: begin
               next_s.pc = s.acc;
               next_s.acc = s.pc + `PC_STEP1;
            end
            default: begin
               // Unused command code does nothing
               next_s.done = s.done;
            end
         endcase
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Reset clears everything and opens the bus channels
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         s <= '0;
         s.rsp.awready <= 1'b1;
         s.rsp.wready <= 1'b1;
         s.rsp.arready <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign axi_rsp = s.rsp; // Registered bus answers
   assign mem_req = s.mem; // Registered memory request

endmodule

/* File: test/cpu_agen_vec_mem.sv */
// Vector table memory model on the far side of the core
`timescale 1ns/1ns

module cpu_agen_vec_mem (
   input wire logic clk_sys, // System clock
   input wire cpu_agen_pkg::mem_req_s mem_req, // Table read request
   output logic [7:0] mem_rdata // Byte answered one cycle later
);
   // ----------------------------------------
   // Synchronous table read
   // ----------------------------------------
   initial mem_rdata = 8'h00;
   // Known pattern while requested, a toggling pattern when idle
   always @(posedge clk_sys) begin
      if (mem_req.rd) begin
         mem_rdata <= mem_req.addr[7:0] ^ 8'h5a;
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

/* File: test/cpu_agen_core_properties.sv */
// Concurrent checks on the ports of the core
`timescale 1ns/1ns

module cpu_agen_checker (
   input wire logic clk_sys, // System clock
   input wire logic srst, // Synchronous reset
   input wire cpu_agen_pkg::axi_req_s axi_req, // Bus requests
   input wire cpu_agen_pkg::axi_rsp_s axi_rsp, // Bus answers
   input wire cpu_agen_pkg::mem_req_s mem_req, // Table reads
   input wire logic [7:0] mem_rdata // Table byte
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   // ----------------------------------------
   // Vector table fetch: high byte, then low byte
   // ----------------------------------------
   sequence s_vec_fetch;
      mem_req.rd ##1
      (mem_req.rd && mem_req.addr == $past(mem_req.addr) + 16'h0001)
      ##1 !mem_req.rd;
   endsequence
   a_vec_steps: assert property ($rose(mem_req.rd) |-> s_vec_fetch)
      else $error("vector fetch sequence broken");
   a_vec_base: assert property ($rose(mem_req.rd) |->
      mem_req.addr[0] == 1'b0 && mem_req.addr[15:4] == 12'hffc)
      else $error("vector fetch starts off an even table entry");
   a_vec_range: assert property (mem_req.rd |->
      mem_req.addr[15:4] == 12'hffc)
      else $error("table read outside the vector table");
   // ----------------------------------------
   // Bus handshakes
   // ----------------------------------------
   // Both channels taken at one edge, write performed at the next,
   // so bvalid is first seen two edges after the take
   a_write_resp: assert property (axi_req.awvalid && axi_rsp.awready &&
      axi_req.wvalid && axi_rsp.wready |=> ##1 axi_rsp.bvalid)
      else $error("write response late");
   a_write_once: assert property (axi_rsp.bvalid && axi_req.bready |=>
      !axi_rsp.bvalid)
      else $error("write response repeated");
   a_write_busy: assert property (axi_rsp.bvalid |->
      !axi_rsp.awready && !axi_rsp.wready)
      else $error("write channel open during response");
   a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready
      |=> axi_rsp.rvalid)
      else $error("read answer late");
   a_read_once: assert property (axi_rsp.rvalid && axi_req.rready |=>
      !axi_rsp.rvalid)
      else $error("read answer repeated");
   a_read_busy: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
      else $error("read channel open during answer");
endmodule

bind cpu_agen_core cpu_agen_checker cpu_agen_checker_inst (
   .clk_sys(clk_sys),
   .srst(srst),
   .axi_req(axi_req),
   .axi_rsp(axi_rsp),
   .mem_req(mem_req),
   .mem_rdata(mem_rdata)
);

/* File: test/test_cpu_agen_core.sv */
// Self-checking bench for the address generation core
`timescale 1ns/1ns
`include "cpu_agen_defines.svh"

module test_cpu_agen_core;
   logic clk_sys = 1'b0; // System clock
   logic srst = 1'b1; // Reset, held at start
   cpu_agen_pkg::axi_req_s axi_req = '0; // Bus requests
   cpu_agen_pkg::axi_rsp_s axi_rsp; // Bus answers
   cpu_agen_pkg::mem_req_s mem_req; // Table reads
   logic [7:0] mem_rdata; // Table byte
   logic [67:0] exp_q[$]; // Expected {resp,data} and mask
   int n_fail = 0; // Mismatches
   int comparisons = 0; // Comparisons made
   logic [15:0] rs = 16'h0040; // Random state

   cpu_agen_core cpu_agen_core_inst (.clk_sys(clk_sys), .srst(srst),
      .axi_req(axi_req), .axi_rsp(axi_rsp), .mem_req(mem_req),
      .mem_rdata(mem_rdata));
   cpu_agen_vec_mem cpu_agen_vec_mem_inst (.clk_sys(clk_sys),
      .mem_req(mem_req), .mem_rdata(mem_rdata));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   always #10 clk_sys = ~clk_sys;

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Masked compare of one bus answer
   task automatic check_word(input logic [67:0] e, input logic [33:0] g);
      comparisons++;
      if (((g ^ e[67:34]) & e[33:0]) !== 34'h0) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e[67:34]);
      end
   endtask

   // Ends the run with counts and verdict
   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Offsets above the status register answer an error
   function automatic logic [1:0] resp_of(input logic [7:0] a);
      return (a > `OFS_STAT) ? `RESP_SLVERR : `RESP_OKAY;
   endfunction

   // Bus write, expected response noted first
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      exp_q.push_back({resp_of(a), 32'h0, 34'h3ffffffff});
      @(posedge clk_sys);
      axi_req.awaddr <= a;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hf;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid <= 1'b1;
      axi_req.bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
         if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
      end while (!axi_rsp.bvalid && n < 100);
      axi_req.bready <= 1'b0;
      if (n >= 100) begin
         n_fail++;
         $display("[FAIL] %0t write hang", $time);
      end
   endtask

   // Bus read, expected value and mask noted first
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m);
      int n;
      n = 0;
      exp_q.push_back({resp_of(a), d, 2'b11, m});
      @(posedge clk_sys);
      axi_req.araddr <= a;
      axi_req.arvalid <= 1'b1;
      axi_req.rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
      end while (!axi_rsp.rvalid && n < 100);
      axi_req.rready <= 1'b0;
      if (n >= 100) begin
         n_fail++;
         $display("[FAIL] %0t read hang", $time);
      end
   endtask

   // ----------------------------------------
   // Monitor: compares each answer with the oldest note
   // ----------------------------------------
   always @(posedge clk_sys) begin
      if (axi_rsp.bvalid && axi_req.bready) begin
         check_word(exp_q.pop_front(), {axi_rsp.bresp, 32'h0});
      end
      if (axi_rsp.rvalid && axi_req.rready) begin
         check_word(exp_q.pop_front(), {axi_rsp.rresp, axi_rsp.rdata});
      end
   end

   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      $display("[FAIL] %0t watchdog expired", $time);
      tally_and_finish;
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int i;
      logic [7:0] o1, o2, opc;
      logic [15:0] base, mptr, ea, a, t, p, xa, xt, xp;
      logic [2:0] bk;
      logic [3:0] c, xc;
      cpu_agen_pkg::op_e m;
      repeat (20) @(posedge clk_sys);
      srst <= 1'b0;
      rd(`OFS_ACC, 32'h0, 32'hffff);
      rd(8'h30, 32'h0, 32'hffffffff);
      wr(8'h30, 32'h1);
      // Operand forms 0..7 twice with random and boundary operands
      for (i = 0; i < 16; i++) begin
         rs = lfsr(rs);
         o1 = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : (i == 9) ? 8'hff : rs[7:0];
         opc = {i[3], rs[14:8]};
         rs = lfsr(rs);
         o2 = rs[7:0];
         base = lfsr(rs);
         mptr = lfsr(base);
         rs = mptr;
         bk = (i == 9) ? 3'h7 : base[2:0];
         m = cpu_agen_pkg::op_e'({1'b0, i[2:0]});
         wr(`OFS_BASE, {16'h0, base});
         wr(`OFS_MPTR, {16'h0, mptr});
         wr(`OFS_BANK, {19'h0, mptr[12:8], 5'h0, bk});
         wr(`OFS_INSN, {8'h0, o2, o1, opc});
         wr(`OFS_CMD, {28'h0, m});
         repeat (20) @(posedge clk_sys);
         case (m)
            cpu_agen_pkg::OP_EXT: ea = {o1, o2};
            cpu_agen_pkg::OP_INDEX: ea = base + {{8{o1[7]}}, o1};
            cpu_agen_pkg::OP_POINTER: ea = mptr;
            cpu_agen_pkg::OP_GENREG: ea = {8'h01, mptr[12:8], opc[2:0]};
            cpu_agen_pkg::OP_VECTOR: ea = 16'hffc0 + {12'h0, opc[2:0], 1'b0};
            default: ea = (o1 < 8'h80) ? {8'h00, o1} :
               16'h0080 + {6'h0, bk, 7'h0} + {9'h0, o1[6:0]};
         endcase
         if (m == cpu_agen_pkg::OP_IMM) begin
            rd(`OFS_DATA, opc[7] ? {16'h0, o1, o2} : {24'h0, o1},
               32'hffff);
         end else begin
            rd(`OFS_EA, {13'h0, opc[2:0], ea},
               (m == cpu_agen_pkg::OP_BIT) ? 32'h7ffff : 32'hffff);
         end
         if (m == cpu_agen_pkg::OP_VECTOR) begin
            rd(`OFS_PC, {16'h0, ea[7:0] ^ 8'h5a, (ea[7:0] + 8'h1) ^ 8'h5a},
               32'hffff);
         end
      end
      // Branches and special operations
      for (i = 0; i < 9; i++) begin
         rs = lfsr(rs);
         p = rs;
         c = rs[3:0];
         a = (i == 8) ? 16'h0 : 16'h1234;
         t = 16'h5678;
         o1 = (i == 0) ? 8'hfe : p[15:8];
         m = (i < 2) ? cpu_agen_pkg::OP_REL : (i == 8) ? cpu_agen_pkg::OP_DIV :
            cpu_agen_pkg::op_e'(4'(i + 7));
         xa = a;
         xt = t;
         xp = p;
         xc = c;
         case (m)
            cpu_agen_pkg::OP_REL: xp = p + 16'h2 + {{8{o1[7]}}, o1};
            cpu_agen_pkg::OP_INHERENT: xp = p + 16'h1;
            cpu_agen_pkg::OP_JUMP_ACC: xp = a;
            cpu_agen_pkg::OP_COPY_PC: begin
               xa = p + 16'h1;
               xp = xa;
            end
            cpu_agen_pkg::OP_MULT: xa = {8'h0, a[7:0]} * {8'h0, t[7:0]};
            cpu_agen_pkg::OP_SWAP: begin
               xp = a;
               xa = p + 16'h1;
            end
            default: if (a == 16'h0) begin
               xa = 16'hffff;
               xc = c | 4'h4;
            end else begin
               xa = t / a;
               xt = t % a;
            end
         endcase
         wr(`OFS_ACC, {16'h0, a});
         wr(`OFS_TEMP, {16'h0, t});
         wr(`OFS_PC, {16'h0, p});
         wr(`OFS_CCR, {28'h0, c});
         wr(`OFS_INSN, {16'h0, o1, 8'h0});
         wr(`OFS_CMD, {28'h0, m});
         repeat (20) @(posedge clk_sys);
         rd(`OFS_ACC, {16'h0, xa}, 32'hffff);
         rd(`OFS_TEMP, {16'h0, xt}, 32'hffff);
         rd(`OFS_PC, {16'h0, xp}, 32'hffff);
         rd(`OFS_CCR, {28'h0, xc}, 32'hf);
      end
      rd(`OFS_STAT, 32'h2, 32'h3);
      wr(`OFS_STAT, 32'h2);
      rd(`OFS_STAT, 32'h0, 32'h3);
      repeat (4) @(posedge clk_sys);
      tally_and_finish;
   end
endmodule
